// ===== logic/spi_master_slave_dma.sv
// Serial master and slave units with byte-stream memory ports.
// Assumes pin routing is set up before enable and that an external
// arbiter serves the memory request/grant ports.
`timescale 1ns/100ps
module spi_master_slave_dma #(
  parameter int MAX_BYTES = 255
) (
  input wire logic I_CLK, // System clock
  input wire logic I_SYS_RST, // Async reset, active high
  input wire logic I_ENABLE, // Block enable
  input wire logic [1:0] I_MODE, // Clock polarity/phase mode
  input wire logic [2:0] I_RATE_SEL, // 0=16M ... 7=125k
  input wire logic I_HIGH_SPEED, // Use 32M high speed master
  input wire logic I_START, // Start master transaction pulse
  input wire logic [7:0] I_TX_COUNT, // Master bytes to send
  input wire logic [7:0] I_RX_COUNT, // Master bytes to receive
  input wire logic [7:0] I_CMD_COUNT, // Leading command bytes
  input wire logic [7:0] I_MEM_RDATA, // Master transmit byte from memory
  input wire logic I_MEM_RVALID, // Transmit byte valid
  input wire logic I_MISO, // Master MISO pin
  output logic O_SCK, // Master serial clock
  output logic O_MOSI, // Master data out
  output logic O_CMD_DATA_SELECT, // Low for command, high for data
  output logic O_MEM_RREQ, // Request next transmit byte
  output logic O_MEM_WVALID, // Received byte valid pulse
  output logic [7:0] O_MEM_WDATA, // Received byte
  output logic O_MASTER_BUSY, // Master transaction running
  output logic O_MASTER_END, // Master transaction ended pulse
  input wire logic I_S_SCK, // Slave clock pin
  input wire logic I_S_MOSI, // Slave data in pin
  input wire logic I_S_CHIP_SELECT_N, // Slave chip select, low active
  output logic O_S_MISO, // Slave MISO output
  output logic O_S_MISO_OE, // Slave MISO output enable
  input wire logic I_SEM_ACQUIRE, // CPU acquires semaphore pulse
  input wire logic I_SEM_RELEASE, // CPU releases semaphore pulse
  input wire logic [7:0] I_S_TX_BYTE, // Slave transmit byte from buffer
  output logic O_SEM_CPU_OWNS, // Semaphore held by CPU
  output logic O_S_RX_VALID, // Slave received byte pulse
  output logic [7:0] O_S_RX_BYTE, // Slave received byte
  output logic O_S_TX_REQ // Slave wants next transmit byte pulse
);
  // Byte counters are eight bits wide, so larger limits cannot be served
  if (MAX_BYTES < 1 || MAX_BYTES > 255)
  begin : g_bad_max_bytes
    $error("MAX_BYTES out of range");
  end

  // ==========================================================
  // Input synchronisers, two flops on every pin input
  logic [1:0] sync_miso, sync_sck, sync_smosi, sync_cs;
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sync_miso <= 2'h0;
      sync_sck <= 2'h0;
      sync_smosi <= 2'h0;
      sync_cs <= 2'h3;
    end
    else
    begin
      sync_miso <= {sync_miso[0], I_MISO};
      sync_sck <= {sync_sck[0], I_S_SCK};
      sync_smosi <= {sync_smosi[0], I_S_MOSI};
      sync_cs <= {sync_cs[0], I_S_CHIP_SELECT_N};
    end
  end
  logic miso_s, sck_s, smosi_s, cs_n_s;
  assign miso_s = sync_miso[1];
  assign sck_s = sync_sck[1];
  assign smosi_s = sync_smosi[1];
  assign cs_n_s = sync_cs[1];

  // Half-period of the serial clock in system cycles
  function automatic logic [11:0] half_div(input logic hs, input logic [2:0] sel);
    logic [11:0] base;
    base = 12'(spi_ms_pkg::HALF_16M);
    if (hs)
      half_div = 12'(spi_ms_pkg::HALF_HS);
    else
      half_div = 12'(base << sel);
  endfunction

  // ==========================================================
  // Master unit
  typedef enum {M_IDLE, M_FETCH, M_WAIT, M_LEAD, M_TRAIL, M_DONE} mstate_t;
  mstate_t mstate, next_mstate;
  logic [11:0] div, next_div;
  logic [7:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic [2:0] bitn, next_bitn;
  logic [7:0] byte_idx, next_byte_idx;
  logic [7:0] tx_n, next_tx_n, rx_n, next_rx_n, cmd_n, next_cmd_n;
  logic cpol, next_cpol, cpha, next_cpha;
  logic sck, next_sck, mosi, next_mosi, cmd_data, next_cmd_data;
  logic rreq, next_rreq, wv, next_wv, mend, next_mend;
  logic [7:0] wdata, next_wdata;
  logic [11:0] half;
  logic [7:0] total;

  assign half = half_div(I_HIGH_SPEED, I_RATE_SEL);
  assign total = (tx_n > rx_n) ? tx_n : rx_n;

  // Master next-state: phase 1 shifts out on the lead edge and samples on the trail edge; phase 0 samples on lead, shifts on trail
  always_comb
  begin
    next_mstate = mstate;
    next_div = div;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_bitn = bitn;
    next_byte_idx = byte_idx;
    next_tx_n = tx_n;
    next_rx_n = rx_n;
    next_cmd_n = cmd_n;
    next_cpol = cpol;
    next_cpha = cpha;
    next_sck = sck;
    next_mosi = mosi;
    next_cmd_data = cmd_data;
    next_rreq = 1'b0;
    next_wv = 1'b0;
    next_wdata = wdata;
    next_mend = 1'b0;
    case (mstate)
      M_IDLE:
      begin
        next_sck = cpol;
        if (I_ENABLE && I_START && (I_TX_COUNT != 8'h0 || I_RX_COUNT != 8'h0))
        begin
          next_tx_n = I_TX_COUNT;
          next_rx_n = I_RX_COUNT;
          next_cmd_n = I_CMD_COUNT;
          next_cpol = I_MODE[spi_ms_pkg::MODE_CPOL_BIT];
          next_cpha = I_MODE[spi_ms_pkg::MODE_CPHA_BIT];
          next_sck = I_MODE[spi_ms_pkg::MODE_CPOL_BIT];
          next_byte_idx = 8'h0;
          next_mstate = M_FETCH;
        end
      end
      M_FETCH:
      begin
        next_cmd_data = (byte_idx >= cmd_n);
        if (byte_idx < tx_n)
        begin
          next_rreq = 1'b1;
          next_mstate = M_WAIT;
        end
        else
        begin
          next_tx_sh = spi_ms_pkg::IDLE_MISO_FILL;
          next_mstate = M_LEAD;
        end
        next_bitn = 3'h7;
        // Reload one short: the count ends at zero, so each half is half cycles
        next_div = half - 12'h1;
      end
      M_WAIT:
      begin
        if (I_MEM_RVALID)
        begin
          next_tx_sh = I_MEM_RDATA;
          next_mstate = M_LEAD;
        end
      end
      M_LEAD:
      begin
        // Phase 0 presents data a half period before the first edge
        if (!cpha)
          next_mosi = tx_sh[7];
        if (div != 12'h0)
          next_div = div - 12'h1;
        else
        begin
          next_div = half - 12'h1;
          next_sck = ~sck;
          if (cpha)
            next_mosi = tx_sh[7];
          else
            next_rx_sh = {rx_sh[6:0], miso_s};
          next_mstate = M_TRAIL;
        end
      end
      M_TRAIL:
      begin
        if (div != 12'h0)
          next_div = div - 12'h1;
        else
        begin
          next_div = half - 12'h1;
          next_sck = ~sck;
          next_tx_sh = {tx_sh[6:0], 1'b0};
          if (cpha)
            next_rx_sh = {rx_sh[6:0], miso_s};
          if (bitn != 3'h0)
          begin
            next_bitn = bitn - 3'h1;
            next_mstate = M_LEAD;
          end
          else
          begin
            if (byte_idx < rx_n)
            begin
              next_wv = 1'b1;
              next_wdata = cpha ? {rx_sh[6:0], miso_s} : rx_sh;
            end
            next_byte_idx = byte_idx + 8'h1;
            next_mstate = (byte_idx + 8'h1 >= total) ? M_DONE : M_FETCH;
          end
        end
      end
      M_DONE:
      begin
        next_mend = 1'b1;
        next_sck = cpol;
        next_mstate = M_IDLE;
      end
      default: next_mstate = M_IDLE;
    endcase
  end

  // Master registers
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      mstate <= M_IDLE;
      div <= 12'h0;
      tx_sh <= 8'h0;
      rx_sh <= 8'h0;
      bitn <= 3'h0;
      byte_idx <= 8'h0;
      tx_n <= 8'h0;
      rx_n <= 8'h0;
      cmd_n <= 8'h0;
      cpol <= 1'b0;
      cpha <= 1'b0;
      sck <= 1'b0;
      mosi <= 1'b0;
      cmd_data <= 1'b1;
      rreq <= 1'b0;
      wv <= 1'b0;
      wdata <= 8'h0;
      mend <= 1'b0;
    end
    else
    begin
      mstate <= next_mstate;
      div <= next_div;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      bitn <= next_bitn;
      byte_idx <= next_byte_idx;
      tx_n <= next_tx_n;
      rx_n <= next_rx_n;
      cmd_n <= next_cmd_n;
      cpol <= next_cpol;
      cpha <= next_cpha;
      sck <= next_sck;
      mosi <= next_mosi;
      cmd_data <= next_cmd_data;
      rreq <= next_rreq;
      wv <= next_wv;
      wdata <= next_wdata;
      mend <= next_mend;
    end
  end
  assign O_SCK = sck;
  assign O_MOSI = mosi;
  assign O_CMD_DATA_SELECT = cmd_data;
  assign O_MEM_RREQ = rreq;
  assign O_MEM_WVALID = wv;
  assign O_MEM_WDATA = wdata;
  logic busy;
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
      busy <= 1'b0;
    else
      busy <= (next_mstate != M_IDLE);
  end
  assign O_MASTER_BUSY = busy;
  assign O_MASTER_END = mend;

  // ==========================================================
  // Slave unit; edges found by oversampling, so only clocks up to
  // the documented 8M ceiling are served reliably
  logic sck_d, sem_cpu, next_sem_cpu;
  logic [7:0] s_rx, next_s_rx, s_tx, next_s_tx, s_rxb, next_s_rxb;
  logic [2:0] s_bit, next_s_bit;
  logic s_miso, next_s_miso, s_oe, next_s_oe, s_rv, next_s_rv, s_treq, next_s_treq;
  logic s_lead, s_trail, s_sample, s_shift;
  assign s_lead = (sck_s != sck_d) && (sck_s != cpol);
  assign s_trail = (sck_s != sck_d) && (sck_s == cpol);
  assign s_sample = cpha ? s_trail : s_lead;
  assign s_shift = cpha ? s_lead : s_trail;

  // Slave next-state and semaphore
  always_comb
  begin
    next_sem_cpu = sem_cpu;
    if (I_SEM_ACQUIRE)
      next_sem_cpu = 1'b1;
    else if (I_SEM_RELEASE)
      next_sem_cpu = 1'b0;
    next_s_rx = s_rx;
    next_s_tx = s_tx;
    next_s_rxb = s_rxb;
    next_s_bit = s_bit;
    next_s_miso = s_miso;
    next_s_rv = 1'b0;
    next_s_treq = 1'b0;
    next_s_oe = I_ENABLE && !cs_n_s;
    if (cs_n_s || !I_ENABLE)
    begin
      next_s_bit = 3'h7;
      // Shift register takes the buffer byte only while the DMA side owns it, else the fill byte
      next_s_tx = sem_cpu ? spi_ms_pkg::IDLE_MISO_FILL : I_S_TX_BYTE;
      next_s_miso = next_s_tx[7];
    end
    else
    begin
      if (s_sample)
      begin
        next_s_rx = {s_rx[6:0], smosi_s};
        if (s_bit == 3'h0)
        begin
          next_s_rxb = {s_rx[6:0], smosi_s};
          next_s_rv = !sem_cpu;
          next_s_treq = !sem_cpu;
          next_s_bit = 3'h7;
          next_s_tx = sem_cpu ? spi_ms_pkg::IDLE_MISO_FILL : I_S_TX_BYTE;
        end
        else
        begin
          next_s_bit = s_bit - 3'h1;
          next_s_tx = {s_tx[6:0], 1'b0};
        end
      end
      if (s_shift)
        next_s_miso = s_tx[7];
    end
  end

  // Slave registers
  always_ff @(posedge I_CLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      sck_d <= 1'b0;
      sem_cpu <= 1'b0;
      s_rx <= 8'h0;
      s_tx <= 8'h0;
      s_rxb <= 8'h0;
      s_bit <= 3'h7;
      s_miso <= 1'b0;
      s_oe <= 1'b0;
      s_rv <= 1'b0;
      s_treq <= 1'b0;
    end
    else
    begin
      sck_d <= sck_s;
      sem_cpu <= next_sem_cpu;
      s_rx <= next_s_rx;
      s_tx <= next_s_tx;
      s_rxb <= next_s_rxb;
      s_bit <= next_s_bit;
      s_miso <= next_s_miso;
      s_oe <= next_s_oe;
      s_rv <= next_s_rv;
      s_treq <= next_s_treq;
    end
  end
  assign O_S_MISO = s_miso;
  assign O_S_MISO_OE = s_oe;
  assign O_SEM_CPU_OWNS = sem_cpu;
  assign O_S_RX_VALID = s_rv;
  assign O_S_RX_BYTE = s_rxb;
  assign O_S_TX_REQ = s_treq;
endmodule

// ===== include/spi_ms_pkg.sv
// Constants shared by the serial master/slave block.
// Assumes a 125 MHz system clock; all counts derive from that rate.
package spi_ms_pkg;
  // ==========================================================
  // Clock and rate constants
  localparam int CLK_HZ = 125000000;
  // Standard master rates in bit/s, index 0 fastest
  localparam int RATE_16M = 16000000;
  localparam int RATE_125K = 125000;
  localparam int RATE_HS = 32000000;
  localparam int SLAVE_MAX_HZ = 8000000;
  // Master half-period counts rounded up so the rate never exceeds the nominal; slave minimum half period in ns rounded down
  localparam int HALF_16M = (CLK_HZ + 2 * RATE_16M - 1) / (2 * RATE_16M);
  localparam int HALF_HS = (CLK_HZ + 2 * RATE_HS - 1) / (2 * RATE_HS);
  localparam int SLAVE_MIN_HALF_NS = 1000000000 / (2 * SLAVE_MAX_HZ);
  // ==========================================================
  // Field widths, mode bit positions and the idle fill byte
  localparam int RATE_SEL_W = 3;
  localparam int MODE_W = 2;
  localparam int CNT_W = 8;
  localparam int DIV_W = 12;
  localparam int MODE_CPHA_BIT = 0;
  localparam int MODE_CPOL_BIT = 1;
  localparam logic [7:0] IDLE_MISO_FILL = 8'hff;
endpackage

// ===== bench/spi_master_slave_dma_properties.sv
// Port-level checker for the serial master/slave block.
// Assumes one system clock domain with an active high async reset.
`timescale 1ns/100ps
module spi_master_slave_dma_properties (
  input wire logic I_CLK, // System clock
  input wire logic I_SYS_RST, // Async reset
  input wire logic I_ENABLE, // Block enable
  input wire logic [1:0] I_MODE, // Polarity/phase
  input wire logic I_START, // Start pulse
  input wire logic [7:0] I_TX_COUNT, // Bytes to send
  input wire logic O_SCK, // Master clock
  input wire logic O_MOSI, // Master data out
  input wire logic O_MEM_RREQ, // Fetch request
  input wire logic O_MEM_WVALID, // Byte stored
  input wire logic O_MASTER_BUSY, // Busy level
  input wire logic O_MASTER_END, // End pulse
  input wire logic I_S_CHIP_SELECT_N, // Slave select
  input wire logic O_S_MISO_OE, // Slave drive enable
  input wire logic I_SEM_ACQUIRE, // Acquire pulse
  input wire logic I_SEM_RELEASE, // Release pulse
  input wire logic O_SEM_CPU_OWNS, // Owner flag
  input wire logic O_S_RX_VALID // Slave byte pulse
);
  // ==========================================
  // Clocking
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SYS_RST);
  // ==========================================
  // Properties; sync lag of four cycles allowed on the select pin
  a_miso_hiz_idle:
    assert property (I_S_CHIP_SELECT_N [*4] |-> !O_S_MISO_OE) else $error("miso driven idle");
  a_mosi_at_sample:
    assert property (O_MASTER_BUSY && $changed(O_SCK) && (O_SCK != (I_MODE[1] ^ I_MODE[0]))
      |-> $stable(O_MOSI)) else $error("mosi moved on sample edge");
  a_sck_quiet_idle:
    assert property ($changed(O_SCK) |-> O_MASTER_BUSY || $past(O_MASTER_BUSY) || $past(I_START))
      else $error("clock moved while idle");
  a_rreq_after_start:
    assert property (I_START && I_ENABLE && !O_MASTER_BUSY && I_TX_COUNT != 8'h00
      |-> ##[1:3] O_MEM_RREQ) else $error("no fetch after start");
  a_wvalid_one_cycle:
    assert property (O_MEM_WVALID |=> !O_MEM_WVALID) else $error("store pulse too long");
  a_end_one_cycle:
    assert property (O_MASTER_END |=> !O_MASTER_END) else $error("end pulse too long");
  a_end_then_idle:
    assert property (O_MASTER_END |-> ##[0:2] !O_MASTER_BUSY) else $error("busy after end");
  a_sem_acquire_wins:
    assert property (I_SEM_ACQUIRE |=> O_SEM_CPU_OWNS) else $error("acquire not taken");
  a_sem_release_drops:
    assert property (I_SEM_RELEASE && !I_SEM_ACQUIRE |=> !O_SEM_CPU_OWNS)
      else $error("release not taken");
  a_rx_held_cpu:
    assert property (O_SEM_CPU_OWNS && $past(O_SEM_CPU_OWNS) |-> !O_S_RX_VALID)
      else $error("byte passed while cpu owns");
endmodule

// ===== bench/spi_slave_model.sv
// External slave device seen by the master side.
// Assumes the bench frames every transfer with chip_select_n low.
`timescale 1ns/100ps
module spi_slave_model (
  input wire logic sck, // Clock from master
  input wire logic mosi, // Data from master
  input wire logic cmd_data, // Command/data select
  input wire logic chip_select_n, // Frame, low active
  input wire logic [1:0] mode, // Polarity/phase in use
  output logic miso // Reply to master
);
  logic [7:0] got [8];
  logic got_cds [8];
  logic [7:0] sh;
  logic [7:0] reply;
  logic last = 1'b0;
  int bit_n = 0;
  int byte_n = 0;
  // Sample edge is rising for modes 0 and 3, falling for 1 and 2
  wire samp = sck ^ mode[1] ^ mode[0];
  // Capture master data MSB first, one byte per eight edges
  always @(posedge samp)
    if (!chip_select_n)
    begin
      sh = {sh[6:0], mosi};
      bit_n++;
      if (bit_n == 8)
      begin
        got[byte_n] = sh;
        got_cds[byte_n] = cmd_data;
        byte_n++;
        bit_n = 0;
      end
    end
  // New frame restarts the counts; the slave never clocks itself
  always @(negedge chip_select_n)
  begin
    bit_n = 0;
    byte_n = 0;
  end
  // Reply changes right after each sample edge; deselected line shows the inverse
  assign reply = 8'hc5 ^ byte_n[7:0];
  assign miso = chip_select_n ? ~last : reply[7 - bit_n];
  always @(miso)
    if (!chip_select_n)
      last = miso;
endmodule

// ===== bench/tb_spi_master_slave_dma.sv
// Self-checking bench for the serial master/slave block.
// Assumes the slave model beside it and the port checker bound below.
`timescale 1ns/100ps
module tb_spi_master_slave_dma;
  logic I_CLK = 0, I_SYS_RST = 1, I_ENABLE = 0, I_HIGH_SPEED = 0, I_START = 0;
  logic I_MEM_RVALID = 0, I_S_SCK = 0, I_S_MOSI = 0, I_S_CHIP_SELECT_N = 1;
  logic I_SEM_ACQUIRE = 0, I_SEM_RELEASE = 0, cs_n = 1, I_MISO, sck_q = 0;
  logic [1:0] I_MODE = 0;
  logic [2:0] I_RATE_SEL = 0;
  logic [7:0] I_TX_COUNT = 0, I_RX_COUNT = 0, I_CMD_COUNT = 0, I_MEM_RDATA = 0;
  logic [7:0] I_S_TX_BYTE = 0, O_MEM_WDATA, O_S_RX_BYTE;
  logic O_SCK, O_MOSI, O_CMD_DATA_SELECT, O_MEM_RREQ, O_MEM_WVALID, O_MASTER_BUSY;
  logic O_MASTER_END, O_S_MISO, O_S_MISO_OE, O_SEM_CPU_OWNS, O_S_RX_VALID, O_S_TX_REQ;
  logic [7:0] txq [$];
  logic [7:0] rxq [$];
  int n_mismatch = 0, tests_run = 0, n_cyc = 0, cyc = 0, per = 0, n_srx = 0, n_stq = 0;

  spi_master_slave_dma dut_u (.I_CLK, .I_SYS_RST, .I_ENABLE, .I_MODE, .I_RATE_SEL,
    .I_HIGH_SPEED, .I_START, .I_TX_COUNT, .I_RX_COUNT, .I_CMD_COUNT, .I_MEM_RDATA,
    .I_MEM_RVALID, .I_MISO, .O_SCK, .O_MOSI, .O_CMD_DATA_SELECT, .O_MEM_RREQ,
    .O_MEM_WVALID, .O_MEM_WDATA, .O_MASTER_BUSY, .O_MASTER_END, .I_S_SCK, .I_S_MOSI,
    .I_S_CHIP_SELECT_N, .O_S_MISO, .O_S_MISO_OE, .I_SEM_ACQUIRE, .I_SEM_RELEASE,
    .I_S_TX_BYTE, .O_SEM_CPU_OWNS, .O_S_RX_VALID, .O_S_RX_BYTE, .O_S_TX_REQ);
  spi_slave_model model (.sck(O_SCK), .mosi(O_MOSI), .cmd_data(O_CMD_DATA_SELECT),
    .chip_select_n(cs_n), .mode(I_MODE), .miso(I_MISO));

  // ==========================================
  // Clock
  initial forever #4 I_CLK = ~I_CLK;
  // Memory side: answer fetches, collect stores, time clock periods
  always @(negedge I_CLK)
  begin
    I_MEM_RVALID <= O_MEM_RREQ;
    if (O_MEM_RREQ) I_MEM_RDATA <= txq.pop_front();
    if (O_MEM_WVALID) rxq.push_back(O_MEM_WDATA);
    if (O_S_RX_VALID) n_srx++;
    if (O_S_TX_REQ) n_stq++;
    sck_q <= O_SCK;
    cyc <= (O_SCK && !sck_q) ? 1 : cyc + 1;
    if (O_SCK && !sck_q) per <= cyc;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge I_CLK)
  begin
    n_cyc++;
    if (n_cyc == 40000)
    begin
      n_mismatch++;
      print_verdict;
    end
  end

  // ==========================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One framed master transaction, waited on under a bound
  task automatic xfer(input logic [1:0] m, input logic [7:0] ntx, nrx, ncmd);
    int n;
    I_MODE = m;
    I_TX_COUNT = ntx;
    I_RX_COUNT = nrx;
    I_CMD_COUNT = ncmd;
    // Frame opens a cycle after the mode settles, so the model sees no false edge
    @(negedge I_CLK) cs_n = 0;
    @(negedge I_CLK) I_START = 1;
    @(negedge I_CLK) I_START = 0;
    check("busy", 1, O_MASTER_BUSY);
    n = 0;
    while (O_MASTER_END !== 1'b1 && n < 30000)
    begin
      @(negedge I_CLK);
      n++;
    end
    check("master end", 1, O_MASTER_END);
    repeat (4) @(negedge I_CLK);
    cs_n = 1;
  endtask
  // Bench acts as outside master on the slave pins at 8 Mbit/s, mode 0
  task automatic sbyte(input logic [7:0] v, output logic [7:0] back);
    I_S_CHIP_SELECT_N = 0;
    #125;
    check("slave oe", 1, O_S_MISO_OE);
    for (int i = 7; i >= 0; i--)
    begin
      I_S_MOSI = v[i];
      #62.5 I_S_SCK = 1;
      back[i] = O_S_MISO;
      #62.5 I_S_SCK = 0;
    end
    #125 I_S_CHIP_SELECT_N = 1;
    #250;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      txq = {8'h3c ^ m[7:0], 8'ha5};
      rxq = {};
      xfer(m[1:0], 8'h02, 8'h03, 8'h01);
      for (int b = 0; b < 3; b++)
      begin
        check("mosi byte", b == 0 ? 8'h3c ^ m[7:0] : b == 1 ? 8'ha5 : 8'hff, model.got[b]);
        check("miso byte", 8'hc5 ^ b[7:0], rxq[b]);
        check("cmd data", b != 0, model.got_cds[b]);
      end
      check("rx count", 3, rxq.size());
      check("idle sck", m[1], O_SCK);
    end
  endtask
  task automatic t_rates;
    int p [9];
    I_HIGH_SPEED = 1;
    txq = {8'h5a};
    xfer(2'b00, 8'h01, 8'h01, 8'h00);
    p[8] = per;
    I_HIGH_SPEED = 0;
    for (int s = 0; s < 8; s++)
    begin
      I_RATE_SEL = s[2:0];
      txq = {8'h5a};
      xfer(2'b00, 8'h01, 8'h01, 8'h00);
      p[s] = per;
    end
    check("fast period", 2 * spi_ms_pkg::HALF_HS, p[8]);
    for (int s = 0; s < 8; s++)
      check("rate period", (2 * spi_ms_pkg::HALF_16M) << s, p[s]);
  endtask
  task automatic t_slave;
    logic [7:0] back;
    check("idle oe", 0, O_S_MISO_OE);
    I_S_TX_BYTE = 8'h96;
    sbyte(8'h3b, back);
    check("slave rx", 8'h3b, O_S_RX_BYTE);
    check("slave tx", 8'h96, back);
    check("rx pulses", 1, n_srx);
    check("tx requests", 1, n_stq);
    @(negedge I_CLK) I_SEM_ACQUIRE = 1;
    @(negedge I_CLK) I_SEM_ACQUIRE = 0;
    check("cpu owns", 1, O_SEM_CPU_OWNS);
    sbyte(8'h11, back);
    check("rx held", 1, n_srx);
    check("tx req held", 1, n_stq);
    check("slave fill", spi_ms_pkg::IDLE_MISO_FILL, back);
    @(negedge I_CLK) I_SEM_RELEASE = 1;
    @(negedge I_CLK) I_SEM_RELEASE = 0;
    check("dma owns", 0, O_SEM_CPU_OWNS);
  endtask

  // Main sequence: reset for 8 cycles, then each scenario in turn
  initial
  begin
    repeat (8) @(negedge I_CLK);
    I_SYS_RST = 0;
    I_ENABLE = 1; // pins count as routed before the block is enabled
    @(negedge I_CLK);
    t_modes;
    $display("modes test done");
    t_rates;
    $display("rates test done");
    t_slave;
    $display("slave test done");
    print_verdict;
  end
endmodule

bind spi_master_slave_dma spi_master_slave_dma_properties chk_u (.I_CLK, .I_SYS_RST,
  .I_ENABLE, .I_MODE, .I_START, .I_TX_COUNT, .O_SCK, .O_MOSI, .O_MEM_RREQ, .O_MEM_WVALID,
  .O_MASTER_BUSY, .O_MASTER_END, .I_S_CHIP_SELECT_N, .O_S_MISO_OE, .I_SEM_ACQUIRE,
  .I_SEM_RELEASE, .O_SEM_CPU_OWNS, .O_S_RX_VALID);
